// ### design/crce_top.sv
// CRC engine with APB registers, an input FIFO and an automatic Flash scan.
// Assumes a Flash that returns a byte one cycle after a read strobe, and
// a core that stops fetching while the stall output is high.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "crce_consts.svh"

// ****************************************************************
// Byte FIFO
// ****************************************************************
module crce_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   // Full and empty come from the level count.
   assign in_ready  = (cnt_q != D[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage is written only on an accepted push.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers and level count.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : crce_fifo

// ****************************************************************
// Engine top
// ****************************************************************
// Function
// RULE1: 32-bit mode uses generator 0x04C11DB7.
// RULE2: Reflected processing, least-significant bit first.
// RULE3: XOR input byte into low result byte.
// RULE4: Eight right shifts, XOR 0xEDB88320 on one.
// RULE5: Width select: zero 32-bit, one 16-bit 0x1021.
// RULE6: Result is 32 or 16 bits wide.
// RULE7: Start value select: zeros or ones.
// RULE8: Init write loads selected start value.
// RULE9: Each input byte write updates result; bus input writes during a Flash scan are accepted and dropped.
// RULE10: Software writes page index, then enable.
// RULE11: Sector count given; sector is 512 bytes.
// RULE12: Control write with enable starts scan.
// RULE13: Core stalled until the scan ends.
// RULE14: Software clears enable before reading result.
// RULE15: Pointer picks result byte, increments per access.
// RULE16: Result holds until init, write or input.
// RULE17: Bit-reverse port returns written byte reversed.
// RULE18: 16-bit mode uses same shift procedure.
// RULE19: Scan reads ascending bytes from page start.
module crce_top
   import crce_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             flash_rd,
   output logic [16:0]      flash_addr,
   input  wire logic [7:0]  flash_rdata,
   output logic             cpu_stall
);
   crce_cfg_s  cfg_q;
   crce_auto_s auto_q;
   crce_auto_e au_q;
   crce_auto_e au_d;
   logic [7:0]  count_q;
   logic [1:0]  ptr_q;
   logic [7:0]  flip_q;
   logic [31:0] crc_q;
   logic [3:0]  bits_q;
   logic [16:0] left_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        flash_rd_q;
   logic        flash_dv_q;
   logic [16:0] flash_addr_q;
   logic        stall_q;
   logic        acc;
   logic        done;
   logic        can;
   logic        fi_valid;
   logic        fi_ready;
   logic [7:0]  fi_data;
   logic        fo_valid;
   logic        fo_ready;
   logic [7:0]  fo_data;
   logic        init_wr;
   logic        dat_wr;
   logic        dat_acc;
   logic        start;
   logic [31:0] init_val;
   logic [31:0] rd_mux;

   // One reflected shift step; the upper half is cleared in 16-bit mode.
   function automatic logic [31:0] crc_step(input logic [31:0] v, input logic p16);
      logic [31:0] s;
      s = v >> 1;
      if (v[0]) begin
         s = s ^ (p16 ? {16'h0000, `CRCE_POLY16} : `CRCE_POLY32); // RULE1 RULE2 RULE4 RULE18
      end
      if (p16) begin
         s[31:16] = 16'h0000; // RULE6
      end
      return s;
   endfunction : crc_step

   // Reverses the bit order of a byte.
   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7 - i];
      end
      return r;
   endfunction : rev8

   // ****************************************************************
   // APB slave
   // ****************************************************************
   // A transfer completes on the edge after pready_q rises.
   assign acc  = psel & penable;
   assign done = acc & pready_q;
   // An input write outside a scan waits while the FIFO is full, which stalls the bus.
   assign can  = ~(pwrite & (paddr == `CRCE_OFF_INPUT) & ~fi_ready & (au_q == AU_IDLE));
   assign init_wr = done & pwrite & (paddr == `CRCE_OFF_CTRL) & pwdata[`CRCE_CTRL_INIT];
   assign dat_acc = done & (paddr == `CRCE_OFF_DATA);
   assign dat_wr  = dat_acc & pwrite;
   assign start   = done & pwrite & (paddr == `CRCE_OFF_CTRL) & auto_q.auto_en
                    & (au_q == AU_IDLE); // RULE12
   // The start value follows the width and value bits of the same control write,
   // so a single write can select a start value and load it.
   assign init_val = ~pwdata[`CRCE_CTRL_VAL] ? `CRCE_INIT_ZERO
                     : (pwdata[`CRCE_CTRL_SEL] ? `CRCE_INIT_ONES16 : `CRCE_INIT_ONES); // RULE7

   // Read data selection.
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (paddr)
         `CRCE_OFF_CTRL:   rd_mux = {30'h00000000, cfg_q.init_ones, cfg_q.poly16};
         `CRCE_OFF_AUTO:   rd_mux = {23'h000000, auto_q};
         `CRCE_OFF_COUNT:  rd_mux = {24'h000000, count_q};
         `CRCE_OFF_PTR:    rd_mux = {30'h00000000, ptr_q};
         `CRCE_OFF_DATA:   rd_mux = {24'h000000, crc_q[ptr_q*8 +: 8]}; // RULE15
         `CRCE_OFF_FLIP:   rd_mux = {24'h000000, rev8(flip_q)}; // RULE17
         `CRCE_OFF_STATUS: rd_mux = {30'h00000000, (bits_q != 4'h0) | fo_valid,
                                     au_q != AU_IDLE};
         default:          rd_mux = 32'h00000000;
      endcase
   end

   // Bus answer flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= acc & ~pready_q & can;
         if (acc & ~pready_q & can) begin
            prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= (paddr > `CRCE_OFF_STATUS) | (paddr[1:0] != 2'b00);
         end
      end
   end

   // Configuration registers and the pointer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q   <= '0;
         auto_q  <= '0;
         count_q <= 8'h00;
         ptr_q   <= 2'h0;
         flip_q  <= 8'h00;
      end else begin
         if (done & pwrite) begin
            unique case (paddr)
               `CRCE_OFF_CTRL: begin
                  cfg_q.poly16    <= pwdata[`CRCE_CTRL_SEL]; // RULE5
                  cfg_q.init_ones <= pwdata[`CRCE_CTRL_VAL]; // RULE7
               end
               `CRCE_OFF_AUTO:  auto_q  <= pwdata[`CRCE_AUTO_EN:0];
               `CRCE_OFF_COUNT: count_q <= pwdata[7:0];
               `CRCE_OFF_PTR:   ptr_q   <= pwdata[1:0];
               `CRCE_OFF_FLIP:  flip_q  <= pwdata[7:0];
               default: begin
               end
            endcase
         end
         if (dat_acc) begin
            ptr_q <= cfg_q.poly16 ? {1'b0, ~ptr_q[0]} : ptr_q + 2'h1; // RULE15
         end
      end
   end

   // ****************************************************************
   // Data path: FIFO and engine
   // ****************************************************************
   // Bus bytes feed the FIFO unless a Flash scan owns it.
   assign fi_valid = (au_q != AU_IDLE) ? flash_dv_q
                     : (done & pwrite & (paddr == `CRCE_OFF_INPUT)); // RULE9
   assign fi_data  = (au_q != AU_IDLE) ? flash_rdata : pwdata[7:0];
   assign fo_ready = (bits_q == 4'h0);

   crce_fifo #(
      .W (8),
      .D (`CRCE_FIFO_DEPTH)
   ) u_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .in_valid  (fi_valid),
      .in_ready  (fi_ready),
      .in_data   (fi_data),
      .out_valid (fo_valid),
      .out_ready (fo_ready),
      .out_data  (fo_data)
   );

   // Result register: init wins, then a data port write, then the engine.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_q  <= `CRCE_INIT_ZERO;
         bits_q <= 4'h0;
      end else begin
         if (fo_valid & fo_ready) begin
            bits_q <= `CRCE_BITS_PER_BYTE;
         end else if (bits_q != 4'h0) begin
            bits_q <= bits_q - 4'h1;
         end
         if (init_wr) begin
            crc_q <= init_val; // RULE8
         end else if (dat_wr) begin
            crc_q[ptr_q*8 +: 8] <= pwdata[7:0];
         end else if (fo_valid & fo_ready) begin
            crc_q[7:0] <= crc_q[7:0] ^ fo_data; // RULE3
         end else if (bits_q != 4'h0) begin
            crc_q <= crc_step(crc_q, cfg_q.poly16); // RULE4 RULE18
         end
      end
   end

   // ****************************************************************
   // Automatic Flash scan
   // ****************************************************************
   // Next state of the scan.
   always_comb begin
      au_d = au_q;
      unique case (au_q)
         AU_IDLE:  if (start) au_d = (count_q == 8'h00) ? AU_DRAIN : AU_ISSUE;
         AU_ISSUE: if (fi_ready) au_d = AU_WAIT;
         AU_WAIT:  if (flash_dv_q) au_d = (left_q == 17'h00001) ? AU_DRAIN : AU_ISSUE;
         AU_DRAIN: if (~fo_valid & (bits_q == 4'h0)) au_d = AU_IDLE;
      endcase
   end

   // Scan address, remaining bytes and Flash strobes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         au_q         <= AU_IDLE;
         left_q       <= 17'h00000;
         flash_addr_q <= 17'h00000;
         flash_rd_q   <= 1'b0;
         flash_dv_q   <= 1'b0;
         stall_q      <= 1'b0;
      end else begin
         au_q       <= au_d;
         flash_rd_q <= (au_q == AU_ISSUE) & fi_ready;
         flash_dv_q <= flash_rd_q;
         stall_q    <= (au_d != AU_IDLE); // RULE13
         if (start) begin
            flash_addr_q <= {auto_q.page, 9'h000}; // RULE19
            left_q       <= {count_q, 9'h000} << (`CRCE_SECTOR_SHIFT - 9); // RULE11
         end else if (flash_dv_q) begin
            flash_addr_q <= flash_addr_q + 17'h00001; // RULE19
            left_q       <= left_q - 17'h00001;
         end
      end
   end

   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign flash_rd   = flash_rd_q;
   assign flash_addr = flash_addr_q;
   assign cpu_stall  = stall_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_INIT: assert property (init_wr |=> crc_q == $past(init_val)) // RULE8
      else $error("Init write did not load the start value.");
   AST_XORIN: assert property (fo_valid & fo_ready & ~init_wr & ~dat_wr
      |=> crc_q[7:0] == $past(crc_q[7:0] ^ fo_data)) // RULE3
      else $error("Input byte not XORed into low byte.");
   AST_SHIFT: assert property ((bits_q != 4'h0) & ~init_wr & ~dat_wr
      |=> crc_q == crc_step($past(crc_q), $past(cfg_q.poly16))) // RULE4
      else $error("Shift step wrong.");
   AST_EIGHT: assert property (fo_valid & fo_ready |=> (bits_q != 4'h0) [*8] ##1 bits_q == 4'h0) // RULE4
      else $error("Byte not processed in eight steps.");
   AST_W16: assert property (cfg_q.poly16 & (bits_q != 4'h0) & ~init_wr & ~dat_wr
      |=> crc_q[31:16] == 16'h0000) // RULE6
      else $error("Upper half set in 16-bit mode.");
   AST_PTR: assert property (dat_acc & ~cfg_q.poly16 & ~(pwrite & paddr == `CRCE_OFF_PTR)
      |=> ptr_q == $past(ptr_q) + 2'h1) // RULE15
      else $error("Pointer did not advance.");
   AST_HOLD: assert property (~init_wr & ~dat_wr & ~fo_valid & (bits_q == 4'h0)
      |=> $stable(crc_q)) // RULE16
      else $error("Result changed without cause.");
   AST_FLIP: assert property (pready_q & ~pwrite & (paddr == `CRCE_OFF_FLIP)
      |-> prdata_q[7:0] == rev8(flip_q)) // RULE17
      else $error("Bit-reverse read wrong.");
   AST_START: assert property (start |=> (au_q != AU_IDLE) & cpu_stall) // RULE12
      else $error("Scan did not start.");
   AST_STALL: assert property (cpu_stall == (au_q != AU_IDLE)) // RULE13
      else $error("Stall does not match scan state.");
   AST_CNT: assert property (start & (count_q != 8'h00)
      |=> left_q == {$past(count_q), 9'h000}) // RULE11
      else $error("Byte count not sectors times 512.");
   // Scan reads come no closer than every third cycle, so each Flash byte
   // is taken before the next address goes out.
   AST_PACE: assert property (flash_rd_q |=> ~flash_rd_q ##1 ~flash_rd_q) // RULE19
      else $error("Flash reads too close together.");
   // A returned Flash byte always finds room in the FIFO, so none is lost.
   AST_ROOM: assert property (flash_dv_q & (au_q != AU_IDLE) |-> fi_ready) // RULE19
      else $error("Flash byte arrived with the FIFO full.");
   // Each accepted Flash byte moves the scan address on by exactly one.
   AST_ADDR: assert property (flash_dv_q // RULE19
      |=> flash_addr_q == $past(flash_addr_q) + 17'h00001)
      else $error("Flash address did not advance by one.");
endmodule : crce_top

// ### design/crce_consts.svh
// Offsets, field positions, reset values and constants of the CRC engine.
// Assumes inclusion by the design file and the testbench only.
`ifndef CRCE_CONSTS_SVH
`define CRCE_CONSTS_SVH
// Register byte offsets on the APB bus.
`define CRCE_OFF_CTRL   8'h00
`define CRCE_OFF_INPUT  8'h04
`define CRCE_OFF_AUTO   8'h08
`define CRCE_OFF_COUNT  8'h0c
`define CRCE_OFF_PTR    8'h10
`define CRCE_OFF_DATA   8'h14
`define CRCE_OFF_FLIP   8'h18
`define CRCE_OFF_STATUS 8'h1c
// Control register bit positions.
`define CRCE_CTRL_SEL  0
`define CRCE_CTRL_VAL  1
`define CRCE_CTRL_INIT 2
// Auto control: page index in [7:0], enable bit position.
`define CRCE_AUTO_EN 8
// Reflected form of the 32-bit generator 32'h04c11db7.
`define CRCE_POLY32 32'hedb88320
// Reflected form of the 16-bit generator 16'h1021.
`define CRCE_POLY16 16'h8408
`define CRCE_INIT_ONES 32'hffffffff
`define CRCE_INIT_ZERO 32'h00000000
// Start value of ones in 16-bit mode, with the upper half kept clear.
`define CRCE_INIT_ONES16 32'h0000ffff
// Sector of 512 bytes expressed as a shift.
`define CRCE_SECTOR_SHIFT 9
`define CRCE_BITS_PER_BYTE 4'h8
`define CRCE_FIFO_DEPTH 32
`endif

// ### design/crce_pkg.sv
// Types shared by the CRC engine.
// Assumes the constants header sits in the same folder.
package crce_pkg;
   // Automatic Flash run states.
   typedef enum logic [1:0] {
      AU_IDLE  = 2'b00,
      AU_ISSUE = 2'b01,
      AU_WAIT  = 2'b10,
      AU_DRAIN = 2'b11
   } crce_auto_e;
   // Polynomial and start value selection.
   typedef struct packed {
      logic poly16;
      logic init_ones;
   } crce_cfg_s;
   // Automatic Flash control fields.
   typedef struct packed {
      logic       auto_en;
      logic [7:0] page;
   } crce_auto_s;
endpackage : crce_pkg

// ### tb/crce_flash_model.sv
// Behavioural Flash byte store that answers the CRC engine's scan reads.
// Assumes a one-cycle read strobe with the byte address beside it.
`timescale 1ns/10ps

// ****************************************************************
// Flash model
// ****************************************************************
module crce_flash_model (
   input  wire logic        clk,
   input  wire logic        rd,
   input  wire logic [16:0] addr,
   output logic [7:0]       rdata
);
   // Starts from a known byte so that an idle bus never shows unknowns.
   initial rdata = 8'h00;

   // Answers a read in the next cycle; between reads the bus keeps toggling,
   // so an engine that samples late picks up a wrong byte.
   always @(posedge clk) begin
      if (rd === 1'b1) begin
         rdata <= addr[7:0] ^ addr[15:8] ^ 8'h5a;
      end else begin
         rdata <= ~rdata;
      end
   end
endmodule : crce_flash_model

// ### tb/crce_top_tb.sv
// Self-checking bench for the CRC engine over APB, with a Flash model.
// Assumes the engine constants header is on the include path.
`timescale 1ns/10ps
`include "crce_consts.svh"

// ****************************************************************
// Bench top
// ****************************************************************
module crce_top_tb;
   logic        pclk, presetn, psel, penable, pwrite, err;
   logic [7:0]  paddr, flash_rdata;
   logic [31:0] pwdata, prdata, rd, r, e;
   logic        pready, pslverr, flash_rd, cpu_stall;
   logic [16:0] flash_addr, exp_a;
   int          failures, num_checks, nrd, bad_a;

   crce_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_rd(flash_rd), .flash_addr(flash_addr),
      .flash_rdata(flash_rdata), .cpu_stall(cpu_stall));
   crce_flash_model i_flash (.clk(pclk), .rd(flash_rd), .addr(flash_addr),
      .rdata(flash_rdata));

   // Clock of 20 ns period.
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Follows every scan read and counts those out of ascending order.
   always @(posedge pclk) begin
      if (flash_rd === 1'b1) begin
         if (flash_addr !== exp_a) bad_a++;
         exp_a++;
         nrd++;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // One APB transfer; holds the request until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 400);
      if (n >= 400) failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Reference byte update, reflected, least-significant bit first.
   function automatic logic [31:0] upd(input logic [31:0] c, input logic [7:0] b,
                                       input logic w16);
      c = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ (w16 ? 32'h00008408 : 32'hedb88320)) : (c >> 1);
      end
      return c;
   endfunction : upd

   // Polls the busy flags, then reads nb result bytes from pointer zero.
   task automatic getres(input int nb);
      int n;
      n = 0;
      do begin
         apb(1'b0, `CRCE_OFF_STATUS, 32'h0);
         n++;
      end while (rd[1:0] !== 2'b00 && n < 3000);
      if (n >= 3000) failures++;
      r = 32'h0;
      apb(1'b1, `CRCE_OFF_PTR, 32'h0);
      for (int i = 0; i < nb; i++) begin
         apb(1'b0, `CRCE_OFF_DATA, 32'h0);
         r[8*i +: 8] = rd[7:0];
      end
   endtask : getres

   // Streams n bytes back to back, past the buffer depth when n is large.
   task automatic t_stream(input logic w16, input logic ones, input int n);
      logic [7:0] b;
      e = ones ? (w16 ? 32'h0000ffff : 32'hffffffff) : 32'h0;
      apb(1'b1, `CRCE_OFF_CTRL, {30'h0, ones, w16});
      apb(1'b1, `CRCE_OFF_CTRL, {29'h0, 1'b1, ones, w16});
      for (int i = 0; i < n; i++) begin
         b = 8'(i * 29 + 99);
         apb(1'b1, `CRCE_OFF_INPUT, {24'h0, b});
         e = upd(e, b, w16);
      end
      getres(w16 ? 2 : 4);
      chk(r, e, "stream result");
      apb(1'b0, `CRCE_OFF_DATA, 32'h0);
      chk(rd[7:0], e[7:0], "pointer wrap");
      $display("test stream w16=%0d ones=%0d n=%0d done", w16, ones, n);
   endtask : t_stream

   // Overwrite through the data port, hold, one more byte, then re-init.
   task automatic t_hold;
      apb(1'b1, `CRCE_OFF_CTRL, 32'h0);
      apb(1'b1, `CRCE_OFF_PTR, 32'h0);
      for (int i = 1; i <= 4; i++) apb(1'b1, `CRCE_OFF_DATA, 32'(i * 17));
      apb(1'b1, `CRCE_OFF_FLIP, 32'h0);
      getres(4);
      chk(r, 32'h44332211, "data port write");
      apb(1'b1, `CRCE_OFF_INPUT, 32'h0);
      getres(4);
      chk(r, upd(32'h44332211, 8'h00, 1'b0), "byte after write");
      apb(1'b1, `CRCE_OFF_CTRL, 32'h2);
      apb(1'b1, `CRCE_OFF_CTRL, 32'h6);
      getres(4);
      chk(r, 32'hffffffff, "init");
      apb(1'b1, `CRCE_OFF_INPUT, 32'h63);
      getres(4);
      chk(r, 32'hf9462090, "known vector");
      $display("test hold done");
   endtask : t_hold

   // Bit reversal of written bytes, plus an unmapped address.
   task automatic t_flip;
      logic [7:0] v;
      logic [7:0] rv;
      for (int i = 0; i < 4; i++) begin
         v = 8'(8'hc0 >> i | 8'h05 << i);
         rv = {<<{v}};
         apb(1'b1, `CRCE_OFF_FLIP, {24'h0, v});
         apb(1'b0, `CRCE_OFF_FLIP, 32'h0);
         chk(rd[7:0], rv, "flip");
      end
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      $display("test flip done");
   endtask : t_flip

   // Automatic scan of one sector from page 3 with the core stalled.
   task automatic t_auto;
      int n;
      n = 0;
      apb(1'b1, `CRCE_OFF_CTRL, 32'h6);
      apb(1'b1, `CRCE_OFF_AUTO, 32'h3);
      apb(1'b1, `CRCE_OFF_AUTO, 32'h103);
      apb(1'b1, `CRCE_OFF_COUNT, 32'h1);
      exp_a = 17'd1536;
      nrd = 0;
      apb(1'b1, `CRCE_OFF_CTRL, 32'h2);
      while (cpu_stall !== 1'b1 && n < 4) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, cpu_stall}, 32'h1, "stall");
      while (cpu_stall !== 1'b0 && n < 20000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20000) failures++;
      chk(nrd, 512, "sector reads");
      chk(bad_a, 0, "read order");
      apb(1'b1, `CRCE_OFF_AUTO, 32'h3);
      e = 32'hffffffff;
      for (int i = 1536; i < 2048; i++) e = upd(e, 8'(i ^ (i >> 8) ^ 8'h5a), 1'b0);
      getres(4);
      chk(r, e, "scan result");
      $display("test auto done");
   endtask : t_auto

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   // Guards against a hang well beyond the expected run length.
   initial begin
      #1000000;
      failures++;
      test_done();
   end

   // Reset, then the scenarios in turn.
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {failures, num_checks, nrd, bad_a} = '0;
      exp_a = 17'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      getres(4);
      chk(r, 32'h0, "reset result");
      t_stream(1'b0, 1'b1, 3);
      t_stream(1'b0, 1'b0, 80);
      t_stream(1'b1, 1'b1, 5);
      t_stream(1'b1, 1'b0, 2);
      t_hold();
      t_flip();
      t_auto();
      test_done();
   end
endmodule : crce_top_tb
